//--- verilog/lcdc_defines.svh
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the host bus
// ----------------------------------------------------------------------
`define LCDC_ADDR_TOTAL_LINE  16'h8004
`define LCDC_ADDR_FRAME_HGT   16'h8005
`define LCDC_ADDR_PITCH_LO    16'h8006
`define LCDC_ADDR_PITCH_HI    16'h8007
`define LCDC_ADDR_STANDBY     16'h8008
`define LCDC_ADDR_DISP_ON     16'h8009
`define LCDC_ADDR_ATTR        16'h800a

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LCDC_RST_REG8         8'h00
`define LCDC_RST_STANDBY      1'b1
`define LCDC_RST_DISP_EN      1'b0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LCDC_BIT_STANDBY      0
`define LCDC_BIT_DISP_EN      0
`define LCDC_ATTR_L3_HI       7
`define LCDC_ATTR_L3_LO       6
`define LCDC_ATTR_L2_HI       5
`define LCDC_ATTR_L2_LO       4
`define LCDC_ATTR_L1_HI       3
`define LCDC_ATTR_L1_LO       2
`define LCDC_ATTR_CUR_HI      1
`define LCDC_ATTR_CUR_LO      0

// ----------------------------------------------------------------------
// Indirect commands
// ----------------------------------------------------------------------
`define LCDC_CMD_POWER_SAVE   8'h01
`define LCDC_CMD_DISP_SWITCH  8'h02

// ----------------------------------------------------------------------
// Wake-up write counts
// ----------------------------------------------------------------------
`define LCDC_WAKE_WR_DIRECT   2'h1
`define LCDC_WAKE_WR_INDIRECT 2'h2

// ----------------------------------------------------------------------
// Flash timing, in frames of the free-running counter
// ----------------------------------------------------------------------
`define LCDC_FLASH_L_FAST_ON  6'h02
`define LCDC_FLASH_L_SLOW_ON  6'h10
`define LCDC_FLASH_C_SLOW_ON  6'h16
`define LCDC_FLASH_C_FAST_ON  6'h2d
`define LCDC_FLASH_MASK_4     6'h03
`define LCDC_FLASH_MASK_32    6'h1f
`define LCDC_FLASH_MASK_64    6'h3f

`endif

//--- verilog/lcdc_pkg.sv
package lcdc_pkg;

  // Power state of the controller, one-hot
  typedef enum logic [2:0] {
    LCDC_PS_SLEEP  = 3'b001,
    LCDC_PS_WAKING = 3'b010,
    LCDC_PS_AWAKE  = 3'b100
  } lcdc_pwr_t;

  // Four-state screen attribute
  typedef enum logic [1:0] {
    LCDC_ATTR_BLANK  = 2'b00,
    LCDC_ATTR_STEADY = 2'b01,
    LCDC_ATTR_SLOW   = 2'b10,
    LCDC_ATTR_FAST   = 2'b11
  } lcdc_attr_t;

endpackage

//--- verilog/lcdc_attr_gate.sv
`timescale 1ns/10ps
module lcdc_attr_gate (
  // Controls
  input  wire logic       enable,
  input  wire logic [1:0] attr,
  // Flash phases
  input  wire logic       slow_on,
  input  wire logic       fast_on,
  // Result
  output logic            visible
);

  always_comb begin
    visible = 1'b0;
    if (enable) begin
      unique case (lcdc_pkg::lcdc_attr_t'(attr))
        lcdc_pkg::LCDC_ATTR_BLANK:  visible = 1'b0;
        lcdc_pkg::LCDC_ATTR_STEADY: visible = 1'b1;
        lcdc_pkg::LCDC_ATTR_SLOW:   visible = slow_on;
        lcdc_pkg::LCDC_ATTR_FAST:   visible = fast_on;
      endcase
    end
  end

endmodule

//--- verilog/lcdc_regs.sv
`timescale 1ns/10ps
`include "lcdc_defines.svh"
module lcdc_regs #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Direct host bus
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  input  wire logic [DATA_W-1:0] bus_wdata,
  output logic      [DATA_W-1:0] bus_rdata,
  // Indirect command path
  input  wire logic              indirect_mode,
  input  wire logic              cmd_wr,
  input  wire logic [DATA_W-1:0] cmd_code,
  input  wire logic              param_wr,
  input  wire logic [DATA_W-1:0] param_data,
  // Core status
  input  wire logic              dual_panel,
  input  wire logic              frame_tick,
  // Configuration out
  output logic      [7:0]        total_line_bytes,
  output logic      [7:0]        frame_height,
  output logic      [15:0]       virtual_line_pitch,
  output logic                   standby,
  output logic                   osc_run,
  output logic                   display_on,
  output logic      [7:0]        layer_cursor_attributes,
  // Visibility out
  output logic                   layer_one_vis,
  output logic                   layer_two_vis,
  output logic                   layer_three_vis,
  output logic                   layer_four_vis,
  output logic                   cursor_vis
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  if (ADDR_W != 16) begin : g_bad_addr
    $error("lcdc_regs needs a 16-bit address");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("lcdc_regs needs an 8-bit data bus");
  end

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  logic                 wr_total;
  logic                 wr_frame;
  logic                 wr_pitch_lo;
  logic                 wr_pitch_hi;
  logic                 wr_standby;
  logic                 wr_disp;
  logic                 wr_attr;
  logic                 cmd_ps;
  logic                 cmd_disp;
  logic                 any_wr;
  logic                 set_ps;
  logic                 clr_ps;
  logic                 attr_armed;
  logic                 param_load;
  logic [1:0]           wake_left;
  lcdc_pkg::lcdc_pwr_t  pwr_state;
  lcdc_pkg::lcdc_pwr_t  next_pwr_state;
  logic [5:0]           frame_cnt;

  assign wr_total    = bus_wr && (bus_addr == `LCDC_ADDR_TOTAL_LINE);
  assign wr_frame    = bus_wr && (bus_addr == `LCDC_ADDR_FRAME_HGT);
  assign wr_pitch_lo = bus_wr && (bus_addr == `LCDC_ADDR_PITCH_LO);
  assign wr_pitch_hi = bus_wr && (bus_addr == `LCDC_ADDR_PITCH_HI);
  assign wr_standby  = bus_wr && (bus_addr == `LCDC_ADDR_STANDBY);
  assign wr_disp     = bus_wr && (bus_addr == `LCDC_ADDR_DISP_ON);
  assign wr_attr     = bus_wr && (bus_addr == `LCDC_ADDR_ATTR);
  // Commands only mean something with indirect addressing selected
  assign cmd_ps      = indirect_mode && cmd_wr &&
                       (cmd_code == `LCDC_CMD_POWER_SAVE);
  assign cmd_disp    = indirect_mode && cmd_wr &&
                       (cmd_code == `LCDC_CMD_DISP_SWITCH);
  assign param_load  = indirect_mode && param_wr && attr_armed;
  assign any_wr      = bus_wr || (indirect_mode && (cmd_wr || param_wr));
  // Standby entry by bit or by command, the command is indirect only
  assign set_ps = (wr_standby && bus_wdata[`LCDC_BIT_STANDBY]) ||
                  cmd_ps;
  assign clr_ps = wr_standby && !bus_wdata[`LCDC_BIT_STANDBY] && !cmd_ps;

  // --------------------------------------------------------------------
  // Plain configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      total_line_bytes <= `LCDC_RST_REG8;
    end else if (wr_total) begin
      total_line_bytes <= bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_height <= `LCDC_RST_REG8;
    end else if (wr_frame) begin
      frame_height <= bus_wdata;
    end
  end

  // No clamp at 7fff: the host keeps the pitch in range
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      virtual_line_pitch <= {`LCDC_RST_REG8, `LCDC_RST_REG8};
    end else begin
      if (wr_pitch_lo) begin
        virtual_line_pitch[7:0] <= bus_wdata;
      end
      if (wr_pitch_hi) begin
        virtual_line_pitch[15:8] <= bus_wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Attributes, from the bus or the display switch parameter
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      attr_armed <= 1'b0;
    end else if (cmd_wr) begin
      attr_armed <= cmd_disp;
    end else if (param_load) begin
      attr_armed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      layer_cursor_attributes <= `LCDC_RST_REG8;
    end else if (param_load) begin
      layer_cursor_attributes <= param_data;
    end else if (wr_attr) begin
      layer_cursor_attributes <= bus_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Power save and display enable
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      standby <= `LCDC_RST_STANDBY;
    end else if (set_ps) begin
      standby <= 1'b1;
    end else if (clr_ps) begin
      standby <= 1'b0;
    end
  end

  // Power save wins over a display write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      display_on <= `LCDC_RST_DISP_EN;
    end else if (set_ps) begin
      display_on <= 1'b0;
    end else if (wr_disp) begin
      display_on <= bus_wdata[`LCDC_BIT_DISP_EN];
    end
  end

  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      lcdc_pkg::LCDC_PS_SLEEP: begin
        if (clr_ps) begin
          next_pwr_state = lcdc_pkg::LCDC_PS_WAKING;
        end
      end
      lcdc_pkg::LCDC_PS_WAKING: begin
        if (set_ps) begin
          next_pwr_state = lcdc_pkg::LCDC_PS_SLEEP;
        end else if (any_wr && (wake_left == 2'h1)) begin
          next_pwr_state = lcdc_pkg::LCDC_PS_AWAKE;
        end
      end
      lcdc_pkg::LCDC_PS_AWAKE: begin
        if (set_ps) begin
          next_pwr_state = lcdc_pkg::LCDC_PS_SLEEP;
        end
      end
      default: next_pwr_state = lcdc_pkg::LCDC_PS_SLEEP;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwr_state <= lcdc_pkg::LCDC_PS_SLEEP;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // The write that clears the bit does not count as a dummy write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_left <= `LCDC_WAKE_WR_DIRECT;
    end else if (pwr_state == lcdc_pkg::LCDC_PS_SLEEP) begin
      wake_left <= indirect_mode ? `LCDC_WAKE_WR_INDIRECT
                                 : `LCDC_WAKE_WR_DIRECT;
    end else if (any_wr && (wake_left != 2'h0)) begin
      wake_left <= wake_left - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      osc_run <= 1'b0;
    end else begin
      osc_run <= (next_pwr_state == lcdc_pkg::LCDC_PS_AWAKE);
    end
  end

  // --------------------------------------------------------------------
  // Frame counter and flash phases
  // --------------------------------------------------------------------
  // One counter feeds every rate so all flashes stay in step
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_cnt <= 6'h00;
    end else if (frame_tick && osc_run) begin
      frame_cnt <= frame_cnt + 6'h01;
    end
  end

  logic l_fast_on;
  logic l_slow_on;
  logic c_slow_on;
  logic c_fast_on;
  logic vis_en;
  logic g_l1;
  logic g_l2;
  logic g_l3;
  logic g_cur;

  // Layers flash at half duty, the cursor at seventy percent
  assign l_fast_on = (frame_cnt & `LCDC_FLASH_MASK_4) <
                     `LCDC_FLASH_L_FAST_ON;
  assign l_slow_on = (frame_cnt & `LCDC_FLASH_MASK_32) <
                     `LCDC_FLASH_L_SLOW_ON;
  assign c_slow_on = (frame_cnt & `LCDC_FLASH_MASK_32) <
                     `LCDC_FLASH_C_SLOW_ON;
  assign c_fast_on = (frame_cnt & `LCDC_FLASH_MASK_64) <
                     `LCDC_FLASH_C_FAST_ON;
  // Master enable overrides every attribute
  assign vis_en = display_on && osc_run;

  lcdc_attr_gate u_gate_l1 (
    .enable  (vis_en),
    .attr    (layer_cursor_attributes[`LCDC_ATTR_L1_HI:`LCDC_ATTR_L1_LO]),
    .slow_on (l_slow_on),
    .fast_on (l_fast_on),
    .visible (g_l1)
  );

  lcdc_attr_gate u_gate_l2 (
    .enable  (vis_en),
    .attr    (layer_cursor_attributes[`LCDC_ATTR_L2_HI:`LCDC_ATTR_L2_LO]),
    .slow_on (l_slow_on),
    .fast_on (l_fast_on),
    .visible (g_l2)
  );

  lcdc_attr_gate u_gate_l3 (
    .enable  (vis_en),
    .attr    (layer_cursor_attributes[`LCDC_ATTR_L3_HI:`LCDC_ATTR_L3_LO]),
    .slow_on (l_slow_on),
    .fast_on (l_fast_on),
    .visible (g_l3)
  );

  lcdc_attr_gate u_gate_cur (
    .enable  (vis_en),
    .attr    (layer_cursor_attributes[`LCDC_ATTR_CUR_HI:`LCDC_ATTR_CUR_LO]),
    .slow_on (c_slow_on),
    .fast_on (c_fast_on),
    .visible (g_cur)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      layer_one_vis   <= 1'b0;
      layer_two_vis   <= 1'b0;
      layer_three_vis <= 1'b0;
      layer_four_vis  <= 1'b0;
      cursor_vis      <= 1'b0;
    end else begin
      layer_one_vis   <= g_l1;
      layer_two_vis   <= g_l2;
      layer_three_vis <= g_l3;
      layer_four_vis  <= dual_panel && g_l2;
      cursor_vis      <= g_cur;
    end
  end

  // --------------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      unique case (bus_addr)
        `LCDC_ADDR_TOTAL_LINE: bus_rdata <= total_line_bytes;
        `LCDC_ADDR_FRAME_HGT:  bus_rdata <= frame_height;
        `LCDC_ADDR_PITCH_LO:   bus_rdata <= virtual_line_pitch[7:0];
        `LCDC_ADDR_PITCH_HI:   bus_rdata <= virtual_line_pitch[15:8];
        `LCDC_ADDR_STANDBY:    bus_rdata <= {7'h00, standby};
        `LCDC_ADDR_DISP_ON:    bus_rdata <= {7'h00, display_on};
        `LCDC_ADDR_ATTR:       bus_rdata <= layer_cursor_attributes;
        default:               bus_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  sequence s_ps_cmd;
    cmd_ps;
  endsequence

  // Parameter strobe right behind the display switch command
  sequence s_disp_param;
    cmd_disp ##1 (param_wr && indirect_mode && !cmd_wr);
  endsequence

  a_reset_sleep_state: assert property (@(posedge sys_clk)
    disable iff (sys_rst) $past(sys_rst) |-> standby && !display_on &&
    !osc_run && (layer_cursor_attributes == 8'h00))
    else $error("reset state wrong");

  a_ps_clears_disp: assert property (@(posedge sys_clk)
    disable iff (sys_rst) set_ps |=> !display_on && standby)
    else $error("power save left display on");

  a_halt_osc_run: assert property (@(posedge sys_clk)
    disable iff (sys_rst) standby |-> !osc_run ##1 !cursor_vis)
    else $error("oscillator runs in power save");

  a_frame_hold: assert property (@(posedge sys_clk)
    disable iff (sys_rst) wr_frame |=> frame_height == $past(bus_wdata))
    else $error("frame height not stored");

  a_pitch_pair: assert property (@(posedge sys_clk)
    disable iff (sys_rst) wr_pitch_hi && !wr_pitch_lo |=>
    (virtual_line_pitch[15:8] == $past(bus_wdata)) &&
    $stable(virtual_line_pitch[7:0]))
    else $error("pitch high byte wrong");

  a_master_blank: assert property (@(posedge sys_clk)
    disable iff (sys_rst) !display_on |=> !cursor_vis && !layer_one_vis &&
    !layer_two_vis && !layer_three_vis && !layer_four_vis)
    else $error("output visible with display off");

  a_layer_steady: assert property (@(posedge sys_clk)
    disable iff (sys_rst) display_on && osc_run &&
    (layer_cursor_attributes[7:6] == 2'b01) |=> layer_three_vis)
    else $error("steady layer three not shown");

  a_dual_share: assert property (@(posedge sys_clk)
    disable iff (sys_rst) ##1 layer_four_vis ==
    ($past(dual_panel) && layer_two_vis))
    else $error("layer four does not follow layer two");

  a_ps_command: assert property (@(posedge sys_clk)
    disable iff (sys_rst) s_ps_cmd |=> standby ##1 !osc_run)
    else $error("power save command ignored");

  a_attr_cmd: assert property (@(posedge sys_clk)
    disable iff (sys_rst) s_disp_param |=>
    layer_cursor_attributes == $past(param_data))
    else $error("display switch parameter not loaded");

  a_cursor_duty: assert property (@(posedge sys_clk)
    disable iff (sys_rst) vis_en && (frame_cnt == 6'h2d) &&
    (layer_cursor_attributes[1:0] == 2'b11) |=> !cursor_vis)
    else $error("cursor on past seventy percent");

  a_frame_free: assert property (@(posedge sys_clk)
    disable iff (sys_rst) frame_tick && osc_run |=>
    frame_cnt == 6'($past(frame_cnt) + 6'h01))
    else $error("frame counter did not advance");

endmodule

//--- bench/lcdc_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host CPU model: one-cycle strobes launched at the falling edge
// ----------------------------------------------------------------
module lcdc_host (
  // Clock
  input  wire logic        sys_clk,
  // Direct bus
  output logic      [15:0] bus_addr,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_rdata,
  // Indirect path
  output logic             indirect_mode,
  output logic             cmd_wr,
  output logic      [7:0]  cmd_code,
  output logic             param_wr,
  output logic      [7:0]  param_data
);
  initial begin
    {bus_addr, bus_wr, bus_rd, bus_wdata, indirect_mode} = '0;
    {cmd_wr, cmd_code, param_wr, param_data} = '0;
  end

  // Released data shows the inverse, so a stale value cannot pass
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask

  // Standby entered by command, not by the bit
  task automatic sleep_cmd();
    @(negedge sys_clk);
    cmd_code = 8'h01;
    cmd_wr = 1'b1;
    @(negedge sys_clk);
    cmd_wr = 1'b0;
    cmd_code = 8'hfe;
  endtask

  // Display switch carries the attribute byte as its parameter
  task automatic disp_cmd(input logic [7:0] p);
    @(negedge sys_clk);
    cmd_code = 8'h02;
    cmd_wr = 1'b1;
    @(negedge sys_clk);
    cmd_wr = 1'b0;
    cmd_code = 8'hfd;
    param_data = p;
    param_wr = 1'b1;
    @(negedge sys_clk);
    param_wr = 1'b0;
    param_data = ~p;
  endtask
endmodule

//--- bench/lcdc_regs_tb.sv
`timescale 1ns/10ps
module lcdc_regs_tb;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        dual_panel = 1'b1;
  logic        frame_tick = 1'b0;
  logic [15:0] bus_addr;
  logic [15:0] virtual_line_pitch;
  logic [7:0]  bus_wdata, bus_rdata, cmd_code, param_data;
  logic [7:0]  total_line_bytes, frame_height, layer_cursor_attributes;
  logic        bus_wr, bus_rd, indirect_mode, cmd_wr, param_wr;
  logic        standby, osc_run, display_on, layer_four_vis;
  logic        layer_one_vis, layer_two_vis, layer_three_vis, cursor_vis;
  logic [3:0]  vis4;
  logic [7:0]  rv;
  int          err_count = 0;
  int          num_checks = 0;
  int          on_n [4];
  int          tg_n [4];

  assign vis4 = {layer_three_vis, layer_two_vis, layer_one_vis, cursor_vis};

  always #10 sys_clk = ~sys_clk;

  lcdc_host host (
    .sys_clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
    .indirect_mode, .cmd_wr, .cmd_code, .param_wr, .param_data
  );

  lcdc_regs DUT (
    .sys_clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
    .indirect_mode, .cmd_wr, .cmd_code, .param_wr, .param_data, .dual_panel,
    .frame_tick, .total_line_bytes, .frame_height, .virtual_line_pitch,
    .standby, .osc_run, .display_on, .layer_cursor_attributes,
    .layer_one_vis, .layer_two_vis, .layer_three_vis, .layer_four_vis,
    .cursor_vis
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(16'(standby), 16'h1);
    chk(16'({display_on, osc_run, vis4, layer_four_vis}), 16'h0);
    for (int i = 4; i <= 10; i++) begin
      host.rd(16'h8000 + 16'(i), rv);
      chk(16'(rv), (i == 8) ? 16'h1 : 16'h0);
    end
  endtask

  // Clearing the bit alone must not restart the oscillator
  task automatic t_wake();
    host.wr(16'h8008, 8'h00);
    chk(16'({standby, osc_run}), 16'h0);
    host.wr(16'h8100, 8'h3c);
    chk(16'({osc_run, display_on}), 16'h2);
    host.wr(16'h8009, 8'h01);
    chk(16'(display_on), 16'h1);
  endtask

  task automatic t_regs();
    logic [15:0] ad [5] = '{16'h8004, 16'h8005, 16'h8006, 16'h8007, 16'h800a};
    logic [7:0]  dv [5] = '{8'hff, 8'hef, 8'hff, 8'h7f, 8'ha5};
    foreach (ad[i]) host.wr(ad[i], dv[i]);
    chk({total_line_bytes, frame_height}, 16'hffef);
    chk(virtual_line_pitch, 16'h7fff);
    chk(16'(layer_cursor_attributes), 16'ha5);
    foreach (ad[i]) begin
      host.rd(ad[i], rv);
      chk(16'(rv), 16'(dv[i]));
    end
    host.rd(16'h8100, rv);
    chk(16'(rv), 16'h0);
  endtask

  task automatic t_vis();
    host.wr(16'h800a, 8'h55);
    @(negedge sys_clk);
    chk(16'({vis4, layer_four_vis}), 16'h1f);
    dual_panel = 1'b0;
    @(negedge sys_clk);
    @(negedge sys_clk);
    chk(16'(layer_four_vis), 16'h0);
    dual_panel = 1'b1;
    host.wr(16'h8009, 8'h00);
    @(negedge sys_clk);
    chk(16'({vis4, layer_four_vis}), 16'h0);
    host.wr(16'h8009, 8'h01);
  endtask

  // Sixty-four frames cover every flash period exactly
  task automatic flash_run(input logic [7:0] at);
    logic [3:0] p;
    host.wr(16'h800a, at);
    @(negedge sys_clk);
    p = vis4;
    on_n = '{default: 0};
    tg_n = '{default: 0};
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      frame_tick = 1'b1;
      @(negedge sys_clk);
      frame_tick = 1'b0;
      @(negedge sys_clk);
      chk(16'(layer_four_vis), 16'(layer_two_vis));
      for (int k = 0; k < 4; k++) begin
        on_n[k] += int'(vis4[k]);
        tg_n[k] += int'(vis4[k] != p[k]);
      end
      p = vis4;
    end
  endtask

  task automatic t_flash();
    logic [7:0] at [2] = '{8'he7, 8'hba};
    int eo [2][4] = '{'{45, 64, 32, 32}, '{44, 32, 32, 32}};
    int et [2][4] = '{'{2, 0, 4, 32}, '{4, 4, 32, 4}};
    for (int r = 0; r < 2; r++) begin
      flash_run(at[r]);
      for (int k = 0; k < 4; k++) begin
        chk(16'(on_n[k]), 16'(eo[r][k]));
        chk(16'(tg_n[k]), 16'(et[r][k]));
      end
    end
  endtask

  // Commands are ignored in direct mode
  task automatic t_sleep();
    host.sleep_cmd();
    chk(16'(standby), 16'h0);
    host.wr(16'h8008, 8'h01);
    chk(16'({standby, display_on, osc_run}), 16'h4);
    @(negedge sys_clk);
    chk(16'({vis4, layer_four_vis}), 16'h0);
  endtask

  task automatic t_indirect();
    host.indirect_mode = 1'b1;
    host.wr(16'h8008, 8'h00);
    host.wr(16'h8100, 8'h00);
    chk(16'(osc_run), 16'h0);
    host.wr(16'h8101, 8'h00);
    chk(16'(osc_run), 16'h1);
    host.disp_cmd(8'h5a);
    chk(16'(layer_cursor_attributes), 16'h5a);
    host.sleep_cmd();
    chk(16'({standby, osc_run}), 16'h2);
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_wake();
    t_regs();
    t_vis();
    t_flash();
    t_sleep();
    t_indirect();
    summarize();
  end
endmodule
